// ==== logic/adcsc_clk_div.v ====
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_defines.vh"

module adcsc_clk_div (
  input  wire       hclk,      // System clock
  input  wire       hresetn,   // Async reset, active low
  input  wire       ce,        // Clock enable
  input  wire       restart,   // Restart the period count
  input  wire [2:0] div_sel,   // Divider code
  output reg        tick_q,    // One pulse per conversion period
  output reg        conv_clk_q // Divided clock level
);

  // ============================================================
  // Period counter
  reg  [`ADCSC_DIV_CNT_W-1:0] cnt_q;    // Cycles into the period
  wire [`ADCSC_DIV_CNT_W-1:0] last;     // Final count of a period
  wire [`ADCSC_DIV_CNT_W-1:0] half;     // Point where clock falls
  wire                        undef;    // Undefined code

  assign last  = ({`ADCSC_DIV_CNT_W{1'b1}} >> (3'h6 - div_sel));
  assign half  = last >> 1;
  assign undef = (div_sel == `ADCSC_DIV_UNDEF);

  // Count the period and emit a tick at its end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q      <= {`ADCSC_DIV_CNT_W{1'b0}};
      tick_q     <= 1'b0;
      conv_clk_q <= 1'b0;
    end else if (ce) begin
      if (restart || undef) begin           // Undefined code stalls
        cnt_q      <= {`ADCSC_DIV_CNT_W{1'b0}};
        tick_q     <= 1'b0;
        conv_clk_q <= 1'b0;
      end else begin
        tick_q <= (cnt_q == last);
        if (cnt_q == last) begin
          cnt_q <= {`ADCSC_DIV_CNT_W{1'b0}};
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
        conv_clk_q <= (last == {`ADCSC_DIV_CNT_W{1'b0}}) ?
                      ~conv_clk_q : (cnt_q <= half);
      end
    end
  end

endmodule // adcsc_clk_div
`default_nettype wire

// ==== logic/adcsc_defines.vh ====
`ifndef ADCSC_DEFINES_VH
`define ADCSC_DEFINES_VH
// ============================================================
// Register byte offsets
`define ADCSC_OFS_PIN_SEL   8'h00
`define ADCSC_OFS_CTRL0     8'h04
`define ADCSC_OFS_CTRL1     8'h08
`define ADCSC_OFS_RES_LOW   8'h0C
`define ADCSC_OFS_RES_HIGH  8'h10
`define ADCSC_OFS_INT_STAT  8'h14
`define ADCSC_OFS_INT_MASK  8'h18
// ============================================================
// Reset values
`define ADCSC_RST_PIN_SEL   8'hFF
`define ADCSC_RST_CHAN      5'h00
`define ADCSC_RST_PWR_OFF   1'h1
`define ADCSC_RST_DIV       3'h0
// ============================================================
// Control zero fields
`define ADCSC_C0_START      7
`define ADCSC_C0_BUSY       6
`define ADCSC_C0_PWR_OFF    5
`define ADCSC_C0_CHAN_HI    4
`define ADCSC_C0_CHAN_LO    0
// ============================================================
// Control one fields
`define ADCSC_C1_REF_SEL    4
`define ADCSC_C1_DIV_HI     2
`define ADCSC_C1_DIV_LO     0
// ============================================================
// Result and interrupt fields
`define ADCSC_RES_HI_MSB    11
`define ADCSC_RES_HI_LSB    8
`define ADCSC_RES_LO_MSB    7
`define ADCSC_INT_EOC       0
// ============================================================
// Divider codes and conversion length
`define ADCSC_DIV_UNDEF     3'h7
`define ADCSC_DIV_CNT_W     6
`define ADCSC_CONV_TICKS    5'h10
`define ADCSC_TICK_ONE      5'h01
// ============================================================
// Converter sequencer states
`define ADCSC_ST_IDLE       2'h0
`define ADCSC_ST_HOLD       2'h1
`define ADCSC_ST_CONV       2'h2
`endif

// ==== logic/adcsc_top.v ====
// Our own choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_defines.vh"

module adcsc_top (
  input  wire        hclk,             // System clock, 100 MHz
  input  wire        hresetn,          // Async reset, active low
  input  wire        ce,               // Clock enable, freezes state
  input  wire        hsel,             // Slave select
  input  wire [31:0] haddr,            // Byte address
  input  wire [1:0]  htrans,           // Transfer type
  input  wire        hwrite,           // Write when high
  input  wire [2:0]  hsize,            // Transfer size
  input  wire [31:0] hwdata,           // Write data
  input  wire        hready,           // Bus ready
  output reg  [31:0] hrdata,           // Read data
  output reg         hreadyout,        // Slave ready
  output reg         hresp,            // Response, always OKAY
  input  wire [11:0] core_result,      // Result from analog core
  output reg  [7:0]  analog_pin_enable_bits, // Pin is analog input
  output reg  [7:0]  pull_high_disconnect,   // Pull-high removed
  output reg  [7:0]  port_a_direction_override, // Direction forced
  output reg  [4:0]  channel_select,   // Channel to the core
  output reg         core_reset,       // Converter held in reset
  output reg         core_power_on,    // Converter powered
  output reg         core_convert,     // Converter running
  output reg         core_clk,         // Conversion clock
  output reg         ref_external,     // Reference from pin
  output reg         ref_pin_function, // Shared pin as reference
  output reg         irq               // Interrupt, active high
);

  // ============================================================
  // Register state
  reg  [7:0]  pin_sel_q;      // Analog pin select
  reg         start_q;        // Start control bit
  reg         pwr_off_q;      // Converter power off
  reg  [4:0]  chan_q;         // Channel select field
  reg         ref_sel_q;      // Reference source select
  reg  [2:0]  div_q;          // Conversion clock divider
  reg  [1:0]  c1_spare_q;     // Control one bits 7 and 6
  reg  [11:0] result_q;       // Last conversion result
  reg         stat_q;         // End-of-conversion status
  reg         mask_q;         // Interrupt enable
  reg         busy_q;         // Conversion busy flag

  // ============================================================
  // Bus state
  reg         dphase_q;       // Data phase pending
  reg         dwrite_q;       // Pending transfer is a write
  reg  [7:0]  daddr_q;        // Pending word address
  wire        take;           // Address phase taken
  wire        wr_en;          // Write strobe in data phase
  reg  [31:0] rd_mux;         // Read data selection

  // ============================================================
  // Sequencer state
  reg  [1:0]  state_q;        // Sequencer state
  reg  [1:0]  state_d;        // Next sequencer state
  reg  [4:0]  ticks_q;        // Conversion periods seen
  wire        div_tick;       // One conversion period elapsed
  wire        div_clk;        // Divided clock level
  wire        start_rise;     // Start bit written high from low
  wire        start_fall;     // Start bit written low from high
  wire        start_new;      // Start value being written
  wire        conv_done;      // Conversion completes this cycle
  wire        stat_clr;       // Software clears the status

  // ============================================================
  // Address phase acceptance, one wait state per transfer
  assign take  = hsel && htrans[1] && hready && hreadyout;
  assign wr_en = dphase_q && dwrite_q;

  // Capture address phase and drive handshake
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dphase_q  <= 1'b0;
      dwrite_q  <= 1'b0;
      daddr_q   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;                        // Always OKAY
      if (take) begin
        dphase_q  <= 1'b1;
        dwrite_q  <= hwrite;
        daddr_q   <= {haddr[7:2], 2'b00};
        hreadyout <= 1'b0;                  // Insert one wait
      end else begin
        dphase_q  <= 1'b0;
        hreadyout <= 1'b1;
      end
    end
  end

  // ============================================================
  // Read data selection, unmapped reads as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    if (daddr_q == `ADCSC_OFS_PIN_SEL) begin
      rd_mux[7:0] = pin_sel_q;
    end else if (daddr_q == `ADCSC_OFS_CTRL0) begin
      rd_mux[`ADCSC_C0_START]   = start_q;
      rd_mux[`ADCSC_C0_BUSY]    = busy_q;
      rd_mux[`ADCSC_C0_PWR_OFF] = pwr_off_q;
      rd_mux[`ADCSC_C0_CHAN_HI:`ADCSC_C0_CHAN_LO] = chan_q;
    end else if (daddr_q == `ADCSC_OFS_CTRL1) begin
      rd_mux[7:6] = c1_spare_q;
      rd_mux[`ADCSC_C1_REF_SEL] = ref_sel_q;
      rd_mux[`ADCSC_C1_DIV_HI:`ADCSC_C1_DIV_LO] = div_q;
    end else if (daddr_q == `ADCSC_OFS_RES_LOW) begin
      rd_mux[7:0] = result_q[`ADCSC_RES_LO_MSB:0];
    end else if (daddr_q == `ADCSC_OFS_RES_HIGH) begin
      rd_mux[3:0] = result_q[`ADCSC_RES_HI_MSB:`ADCSC_RES_HI_LSB];
    end else if (daddr_q == `ADCSC_OFS_INT_STAT) begin
      rd_mux[`ADCSC_INT_EOC] = stat_q;
    end else if (daddr_q == `ADCSC_OFS_INT_MASK) begin
      rd_mux[`ADCSC_INT_EOC] = mask_q;
    end
  end

  // Register read data at the end of the wait state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (dphase_q && !dwrite_q) begin
        hrdata <= rd_mux;
      end
    end
  end

  // ============================================================
  // Software-written configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_sel_q  <= `ADCSC_RST_PIN_SEL;
      start_q    <= 1'b0;
      pwr_off_q  <= `ADCSC_RST_PWR_OFF;
      chan_q     <= `ADCSC_RST_CHAN;
      ref_sel_q  <= 1'b0;
      div_q      <= `ADCSC_RST_DIV;
      c1_spare_q <= 2'b00;
      mask_q     <= 1'b0;
    end else if (ce && wr_en) begin
      if (daddr_q == `ADCSC_OFS_PIN_SEL) begin
        pin_sel_q <= hwdata[7:0];
      end else if (daddr_q == `ADCSC_OFS_CTRL0) begin
        start_q   <= hwdata[`ADCSC_C0_START];
        pwr_off_q <= hwdata[`ADCSC_C0_PWR_OFF];
        chan_q    <= hwdata[`ADCSC_C0_CHAN_HI:`ADCSC_C0_CHAN_LO];
      end else if (daddr_q == `ADCSC_OFS_CTRL1) begin
        c1_spare_q <= hwdata[7:6];
        ref_sel_q  <= hwdata[`ADCSC_C1_REF_SEL];
        div_q      <= hwdata[`ADCSC_C1_DIV_HI:`ADCSC_C1_DIV_LO];
      end else if (daddr_q == `ADCSC_OFS_INT_MASK) begin
        mask_q <= hwdata[`ADCSC_INT_EOC];
      end
    end
  end

  // ============================================================
  // Start bit edges seen as software writes it
  assign start_new  = (wr_en && daddr_q == `ADCSC_OFS_CTRL0) ?
                      hwdata[`ADCSC_C0_START] : start_q;
  assign start_rise = start_new && !start_q;
  assign start_fall = !start_new && start_q;

  // ============================================================
  // Conversion clock divider
  // Divider restarts whenever the sequencer leaves conversion,
  // so every conversion sees whole periods from its first cycle
  adcsc_clk_div u_div (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .restart    (state_q != `ADCSC_ST_CONV),
    .div_sel    (div_q),
    .tick_q     (div_tick),
    .conv_clk_q (div_clk)
  );

  // Sixteenth period end closes the conversion
  assign conv_done = (state_q == `ADCSC_ST_CONV) && div_tick &&
                     (ticks_q == `ADCSC_CONV_TICKS - `ADCSC_TICK_ONE);

  // ============================================================
  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      `ADCSC_ST_IDLE: begin
        if (start_rise) begin
          state_d = `ADCSC_ST_HOLD;
        end
      end
      `ADCSC_ST_HOLD: begin
        if (start_fall) begin
          state_d = `ADCSC_ST_CONV;
        end
      end
      `ADCSC_ST_CONV: begin
        if (start_rise) begin
          state_d = `ADCSC_ST_HOLD;
        end else if (conv_done) begin
          state_d = `ADCSC_ST_IDLE;
        end
      end
      default: begin
        state_d = `ADCSC_ST_IDLE;
      end
    endcase
  end

  // Sequencer state, period count, busy and result
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q  <= `ADCSC_ST_IDLE;
      ticks_q  <= 5'h00;
      busy_q   <= 1'b0;
      result_q <= 12'h000;
    end else if (ce) begin
      state_q <= state_d;
      if (state_q != `ADCSC_ST_CONV) begin
        ticks_q <= 5'h00;
      end else if (div_tick) begin
        ticks_q <= ticks_q + `ADCSC_TICK_ONE;
      end
      busy_q <= (state_d != `ADCSC_ST_IDLE);
      if (conv_done) begin
        result_q <= core_result;
      end
    end
  end

  // ============================================================
  // Interrupt status, set wins over write-one-to-clear
  assign stat_clr = wr_en && (daddr_q == `ADCSC_OFS_INT_STAT) &&
                    hwdata[`ADCSC_INT_EOC];

  // Mask is used as registered, so irq trails a mask write by a cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= 1'b0;
      irq    <= 1'b0;
    end else if (ce) begin
      if (conv_done) begin
        stat_q <= 1'b1;
      end else if (stat_clr) begin
        stat_q <= 1'b0;
      end
      irq <= (conv_done || (stat_q && !stat_clr)) && mask_q;
    end
  end

  // ============================================================
  // Converter and pin control outputs
  // Each output copies registered state one cycle late
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      analog_pin_enable_bits    <= `ADCSC_RST_PIN_SEL;
      pull_high_disconnect      <= `ADCSC_RST_PIN_SEL;
      port_a_direction_override <= `ADCSC_RST_PIN_SEL;
      channel_select            <= `ADCSC_RST_CHAN;
      core_reset                <= 1'b0;
      core_power_on             <= 1'b0;
      core_convert              <= 1'b0;
      core_clk                  <= 1'b0;
      ref_external              <= 1'b0;
      ref_pin_function          <= 1'b0;
    end else if (ce) begin
      analog_pin_enable_bits    <= pin_sel_q;
      pull_high_disconnect      <= pin_sel_q;
      port_a_direction_override <= pin_sel_q;
      channel_select            <= chan_q;
      core_reset   <= (state_q == `ADCSC_ST_HOLD);
      core_power_on <= !pwr_off_q;
      core_convert <= (state_q == `ADCSC_ST_CONV);
      core_clk     <= div_clk;
      ref_external     <= ref_sel_q;
      ref_pin_function <= ref_sel_q;
    end
  end

endmodule // adcsc_top
`default_nettype wire

// ==== verif/adcsc_chk.sv ====
`timescale 1ns/10ps
`default_nettype none
// ============================================================
// Port checker for the converter control block
module adcsc_chk (
  input wire logic        hclk,                  // System clock
  input wire logic        hresetn,               // Reset, active low
  input wire logic        hsel,                  // Slave select
  input wire logic [1:0]  htrans,                // Transfer type
  input wire logic        hready,                // Bus ready
  input wire logic        hreadyout,             // Slave ready
  input wire logic        hresp,                 // Response
  input wire logic [31:0] hrdata,                // Read data
  input wire logic [7:0]  analog_pin_enable_bits, // Analog pins
  input wire logic [7:0]  pull_high_disconnect,  // Pull-high off
  input wire logic [7:0]  port_a_direction_override, // Dir forced
  input wire logic        core_reset,            // Core in reset
  input wire logic        core_convert,          // Core running
  input wire logic        core_clk,              // Conversion clock
  input wire logic        ref_external,          // External reference
  input wire logic        ref_pin_function       // Pin as reference
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_pin_mirror: assert property (
    pull_high_disconnect == analog_pin_enable_bits &&
    port_a_direction_override == analog_pin_enable_bits)
    else $error("pin override outputs differ from pin select");
  chk_ref_pin: assert property (
    ref_external == ref_pin_function)
    else $error("shared pin not following reference select");
  chk_reset_idle: assert property (
    core_reset |-> !core_convert)
    else $error("converter runs while held in reset");
  chk_conv_len: assert property (
    $rose(core_convert) |-> core_convert [*8])
    else $error("conversion ended too soon");
  chk_clk_still: assert property (
    !core_convert ##1 !core_convert |=> $stable(core_clk))
    else $error("conversion clock runs while idle");
  chk_ready_wait: assert property (
    hsel && htrans[1] && hready && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("wait state not exactly one cycle");
  chk_resp_okay: assert property (
    hresp == 1'b0)
    else $error("response not OKAY");
  chk_rdata_hold: assert property (
    hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a transfer");
endmodule // adcsc_chk
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "adcsc_defines.vh"
// ============================================================
// Self-checking bench
module tb_top;
  logic        hclk = 1'b0;      // System clock
  logic        hresetn = 1'b0;   // Reset, active low
  logic        ce = 1'b1;        // Clock enable
  logic        hsel = 1'b0;      // Slave select
  logic        hwrite = 1'b0;    // Write strobe
  logic [1:0]  htrans = 2'h0;    // Transfer type
  logic [31:0] haddr = 32'h0;    // Address
  logic [31:0] hwdata = 32'h0;   // Write data
  logic [11:0] core_result = 12'h000; // Core result
  wire  [31:0] hrdata;           // Read data
  wire  [7:0]  pin_en, pull_off, dir_ovr; // Pin outputs
  wire  [4:0]  chan_sel;         // Channel
  wire         hreadyout, hresp, irq, core_reset, core_power_on;
  wire         core_convert, core_clk, ref_external, ref_pin_function;
  int          fail_count = 0;   // Mismatches
  int          cmp_count = 0;    // Comparisons

  always #5 hclk = ~hclk;

  adcsc_top dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .core_result(core_result),
    .analog_pin_enable_bits(pin_en), .pull_high_disconnect(pull_off),
    .port_a_direction_override(dir_ovr), .channel_select(chan_sel),
    .core_reset(core_reset), .core_power_on(core_power_on),
    .core_convert(core_convert), .core_clk(core_clk),
    .ref_external(ref_external), .ref_pin_function(ref_pin_function),
    .irq(irq));

  // ============================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      fail_count++;
      $display("mismatch %0t count %0d outside %0d..%0d", $time, n, lo, hi);
    end
  endtask

  // Count edges until the converter stops, sampled after outputs settle
  task automatic wait_idle(output int n);
    for (n = 1; n < 3000 && (n < 3 || core_convert === 1'b1); n++) begin
      @(posedge hclk);
      #1;
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset;
    rd_chk(`ADCSC_OFS_PIN_SEL, 32'hFF);
    rd_chk(`ADCSC_OFS_CTRL0, 32'h20);
    chk(core_power_on, 32'h0);
    chk(pin_en, 32'hFF);
  endtask

  task automatic t_pins;
    wr(`ADCSC_OFS_PIN_SEL, 32'h5A);
    rd_chk(`ADCSC_OFS_PIN_SEL, 32'h5A);
    chk({pull_off, dir_ovr, pin_en}, 32'h5A5A5A);
    rd_chk(8'h40, 32'h0);
  endtask

  task automatic t_ref;
    wr(`ADCSC_OFS_CTRL1, 32'h10);
    chk({ref_external, ref_pin_function}, 32'h3);
    wr(`ADCSC_OFS_CTRL1, 32'h0);
    chk({ref_external, ref_pin_function}, 32'h0);
  endtask

  // One full conversion at a divider code, then interrupt handling
  task automatic t_conv(input logic [2:0] code);
    int n;
    int p;
    p = 1 << code;
    @(posedge hclk);
    core_result <= 12'hA50 + code;
    wr(`ADCSC_OFS_CTRL1, {29'h0, code});
    wr(`ADCSC_OFS_CTRL0, 32'h83);
    rd_chk(`ADCSC_OFS_CTRL0, 32'hC3);
    chk({core_reset, core_power_on, chan_sel}, 32'h63);
    wr(`ADCSC_OFS_CTRL0, 32'h03);
    wait_idle(n);
    chk_rng(n, 16 * p - 4, 16 * p + p + 4);
    rd_chk(`ADCSC_OFS_CTRL0, 32'h03);
    rd_chk(`ADCSC_OFS_RES_LOW, 32'h50 + code);
    rd_chk(`ADCSC_OFS_RES_HIGH, 32'hA);
    rd_chk(`ADCSC_OFS_INT_STAT, 32'h1);
    chk(irq, 32'h0);
    wr(`ADCSC_OFS_INT_MASK, 32'h1);
    chk(irq, 32'h1);
    wr(`ADCSC_OFS_INT_STAT, 32'h1);
    chk(irq, 32'h0);
    rd_chk(`ADCSC_OFS_INT_STAT, 32'h0);
    wr(`ADCSC_OFS_INT_MASK, 32'h0);
  endtask

  // Undefined code stalls; a new start rise aborts into reset
  task automatic t_stall;
    wr(`ADCSC_OFS_CTRL1, 32'h7);
    wr(`ADCSC_OFS_CTRL0, 32'h83);
    wr(`ADCSC_OFS_CTRL0, 32'h03);
    repeat (200) @(posedge hclk);
    rd_chk(`ADCSC_OFS_CTRL0, 32'h43);
    wr(`ADCSC_OFS_CTRL0, 32'h83);
    rd_chk(`ADCSC_OFS_CTRL0, 32'hC3);
    chk(core_reset, 32'h1);
    t_conv(3'h1);
  endtask

  // Clock enable low freezes a running conversion
  task automatic t_freeze;
    int n;
    wr(`ADCSC_OFS_CTRL1, 32'h0);
    wr(`ADCSC_OFS_CTRL0, 32'h83);
    wr(`ADCSC_OFS_CTRL0, 32'h03);
    @(posedge hclk);
    ce <= 1'b0;
    repeat (40) @(posedge hclk);
    chk(core_convert, 32'h1);
    ce <= 1'b1;
    wait_idle(n);
    chk_rng(n, 12, 21);
    rd_chk(`ADCSC_OFS_INT_STAT, 32'h1);
    wr(`ADCSC_OFS_INT_STAT, 32'h1);
  endtask

  task automatic t_power;
    wr(`ADCSC_OFS_CTRL0, 32'h20);
    chk(core_power_on, 32'h0);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ============================================================
  // Main sequence and watchdog
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_pins;
    t_ref;
    // Only code 6 meets the period floor; faster codes test timing only
    for (int c = 0; c < 7; c++) t_conv(c[2:0]);
    t_freeze;
    t_stall;
    t_power;
    close_out;
  end

  initial begin
    #400000;
    fail_count++;
    close_out;
  end
endmodule // tb_top

bind adcsc_top adcsc_chk u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata),
  .analog_pin_enable_bits(analog_pin_enable_bits),
  .pull_high_disconnect(pull_high_disconnect),
  .port_a_direction_override(port_a_direction_override),
  .core_reset(core_reset), .core_convert(core_convert),
  .core_clk(core_clk), .ref_external(ref_external),
  .ref_pin_function(ref_pin_function));
`default_nettype wire
